// ===== hw/dacc_defs.vh
// Purpose: Shared constants of the two-channel converter control block
// Assumes: 32-bit APB data, byte addresses, 250 MHz peripheral clock
// Notes: Definitions only
`ifndef DACC_DEFS_VH
`define DACC_DEFS_VH

// Register byte offsets
`define DACC_OFF_CODE_CH0 8'h00
`define DACC_OFF_CODE_CH1 8'h04
`define DACC_OFF_CONTROL 8'h08
`define DACC_OFF_STATUS 8'h0c
`define DACC_ADDR_W 8

// Control register fields
`define DACC_CTL_OE1 7
`define DACC_CTL_OE0 6
`define DACC_CTL_JOINT 5
`define DACC_CTL_RSVD_ONES 5'h1f

// Status register fields
`define DACC_STS_VALID0 0
`define DACC_STS_VALID1 1
`define DACC_STS_STOP 2
`define DACC_STS_STANDBY 3

// Reset values
`define DACC_CODE_RST 8'h00
`define DACC_CTL_BITS_RST 3'h0
`define DACC_DATA_ZERO 32'h0000_0000

// Timing: conversion time and clock period in ns; shortest count in cycles
`define DACC_CONV_TIME_NS 10000
`define DACC_CLK_PERIOD_NS 4
`define DACC_PS_PER_NS 1000
`define DACC_CONV_MIN 1
`define DACC_LOAD_NONE 2'h0

`endif

// ===== hw/dacc_sync.v
// Purpose: Two-flop synchroniser for a level from outside the clock domain
// Assumes: Input is a slowly changing level
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module dacc_sync #(
    parameter RST_VAL = 1'b0
) (
    input wire mclk_i,
    input wire nrst_i,
    input wire async_i,
    output wire sync_o
);
    reg meta_q;
    reg sync_q;

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // dacc_sync

// ===== hw/dacc_chan.v
// Purpose: One conversion channel: conversion timer and held result
// Assumes: load_i pulses in the cycle the data register takes a new code
// Notes: Result is sampled from code_i when the timer expires
`timescale 1ns/1ps
`include "dacc_defs.vh"
module dacc_chan #(
    parameter CONV_CYCLES = 2500,
    parameter CNT_W = 12
) (
    input wire mclk_i,
    input wire nrst_i,
    input wire conv_en_i,
    input wire load_i,
    input wire hold_i,
    input wire [7:0] code_i,
    output reg [7:0] result_o,
    output reg valid_o
);
    localparam [CNT_W-1:0] CNT_LOAD = CONV_CYCLES[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

    reg en_q;
    reg [CNT_W-1:0] cnt_q;
    wire start;

    // A fresh enable or a rewrite while enabled restarts the timer
    assign start = conv_en_i & (~en_q | load_i);

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_q <= 1'b0;
            cnt_q <= CNT_ZERO;
            result_o <= `DACC_CODE_RST;
            valid_o <= 1'b0;
        end else if (hold_i) begin
            // Standby: counter frozen, result kept on the output
            en_q <= en_q;
        end else begin
            en_q <= conv_en_i;
            if (!conv_en_i) begin
                cnt_q <= CNT_ZERO;
                valid_o <= 1'b0;
            end else if (start) begin
                cnt_q <= CNT_LOAD;
                valid_o <= 1'b0;
            end else if (cnt_q == CNT_ONE) begin
                cnt_q <= CNT_ZERO;
                result_o <= code_i;
                valid_o <= 1'b1;
            end else if (cnt_q != CNT_ZERO) begin
                cnt_q <= cnt_q - CNT_ONE;
            end
        end
    end
endmodule // dacc_chan

// ===== hw/dacc_top.v
// Purpose: Two-channel 8-bit converter control with an APB register slave
// Assumes: module_stop_i and standby_i come from outside this clock domain
// Notes: Analog core takes code and drive enable; it scales code/256 x Vref
//
// Summary of operation
// - Bit 7 enables channel one conversion, output
// - Bit 6 enables channel zero conversion, output
// - Bit 5 set converts both channels always; the code halts conversion during module stop
// - All three bits zero: no conversion
// - Output drive follows only own enable bit; the code also drops drive during module stop
// - Control bits four to zero read ones
// - Channels independent: own code, enable, output
// - Enabling starts conversion; result after conversion time
// - Result held until rewrite or disable
// - Write while enabled restarts conversion immediately; in standby the code holds the restart pending until standby ends
// - Output level is code/256 times reference
// - Clearing enable disables output immediately
// - Module stop blocks register access until cleared
// - Standby keeps enabled outputs presented
// - Code registers: 8-bit, read/write, reset zero
`timescale 1ns/1ps
`include "dacc_defs.vh"
module dacc_top #(
    parameter CONV_TIME_NS = `DACC_CONV_TIME_NS,
    parameter CLK_PERIOD_PS = `DACC_CLK_PERIOD_NS * `DACC_PS_PER_NS,
    parameter CNT_W = 12
) (
    input wire mclk_i,
    input wire nrst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`DACC_ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire module_stop_i,
    input wire standby_i,
    output reg [7:0] analog_out_ch0_o,
    output reg [7:0] analog_out_ch1_o,
    output reg drive_ch0_o,
    output reg drive_ch1_o,
    output reg valid_ch0_o,
    output reg valid_ch1_o
);
    // Longest time: round down, never below one cycle, saturate at the timer
    // width so an oversized time cannot wrap to a short count
    localparam CONV_RAW = (CONV_TIME_NS * `DACC_PS_PER_NS) / CLK_PERIOD_PS;
    localparam CNT_MAX = (1 << CNT_W) - 1;
    localparam CONV_CYCLES = (CONV_RAW < `DACC_CONV_MIN) ? `DACC_CONV_MIN :
        ((CONV_RAW > CNT_MAX) ? CNT_MAX : CONV_RAW);

    // APB access phase states, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [7:0] code_q [0:1];
    reg oe1_q;
    reg oe0_q;
    reg joint_q;
    reg [31:0] rdata_d;
    reg err_d;
    reg [1:0] load_q;
    reg [1:0] pend_q;

    wire stop_s;
    wire standby_s;
    wire wr_commit;
    wire [1:0] conv_en;
    wire [1:0] oe;
    wire [7:0] result [0:1];
    wire [1:0] valid;
    wire [1:0] we_code;
    wire we_ctl;
    wire [1:0] load;

    function hit;
        input [`DACC_ADDR_W-1:0] addr;
        input [`DACC_ADDR_W-1:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // Control word as software reads it; bits four to zero are fixed ones
    function [31:0] ctl_word;
        input oe1;
        input oe0;
        input joint;
        begin
            ctl_word = `DACC_DATA_ZERO;
            ctl_word[`DACC_CTL_OE1] = oe1;
            ctl_word[`DACC_CTL_OE0] = oe0;
            ctl_word[`DACC_CTL_JOINT] = joint;
            ctl_word[4:0] = `DACC_CTL_RSVD_ONES;
        end
    endfunction

    // Status word: internal valid flags and the synchronised power states
    function [31:0] sts_word;
        input [1:0] vld;
        input stop;
        input stby;
        begin
            sts_word = `DACC_DATA_ZERO;
            sts_word[`DACC_STS_VALID0] = vld[0];
            sts_word[`DACC_STS_VALID1] = vld[1];
            sts_word[`DACC_STS_STOP] = stop;
            sts_word[`DACC_STS_STANDBY] = stby;
        end
    endfunction

    // Stop starts set: the block leaves reset stopped and refuses access
    // until the cleared level has crossed both flops
    dacc_sync #(
        .RST_VAL(1'b1)
    ) u_stop_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .async_i(module_stop_i),
        .sync_o(stop_s)
    );

    dacc_sync #(
        .RST_VAL(1'b0)
    ) u_standby_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .async_i(standby_i),
        .sync_o(standby_s)
    );

    // APB handshake: two wait states, answer in the fourth cycle of the transfer
    always @* begin
        case (state_q)
            ST_IDLE: begin
                if (psel_i && penable_i) begin
                    state_d = ST_WAIT;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_WAIT: begin
                state_d = ST_DONE;
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Read mux and error decode; sampled on the edge that leaves the wait state
    always @* begin
        rdata_d = `DACC_DATA_ZERO;
        err_d = 1'b0;
        if (stop_s) begin
            err_d = 1'b1;
        end else if (hit(paddr_i, `DACC_OFF_CODE_CH0)) begin
            rdata_d[7:0] = code_q[0];
        end else if (hit(paddr_i, `DACC_OFF_CODE_CH1)) begin
            rdata_d[7:0] = code_q[1];
        end else if (hit(paddr_i, `DACC_OFF_CONTROL)) begin
            rdata_d = ctl_word(oe1_q, oe0_q, joint_q);
        end else if (hit(paddr_i, `DACC_OFF_STATUS)) begin
            rdata_d = sts_word(valid, stop_s, standby_s);
        end else begin
            err_d = 1'b1;
        end
    end

    // Ready is registered from the next state, so it stands for exactly one
    // cycle and the master never sees it twice for one transfer
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= `DACC_DATA_ZERO;
        end else begin
            state_q <= state_d;
            pready_o <= (state_d == ST_DONE);
            // Read data stands only in the answer cycle; writes return zero
            if (state_q == ST_WAIT) begin
                prdata_o <= pwrite_i ? `DACC_DATA_ZERO : rdata_d;
                pslverr_o <= err_d;
            end else if (state_q == ST_DONE) begin
                prdata_o <= `DACC_DATA_ZERO;
                pslverr_o <= 1'b0;
            end
        end
    end

    // Writes land on the edge where the master sees pready high
    assign wr_commit = (state_q == ST_DONE) & psel_i & penable_i & pwrite_i
        & ~pslverr_o & pstrb_i[0];

    // One strobe per register keeps the decode out of the register process
    assign we_code[0] = wr_commit & hit(paddr_i, `DACC_OFF_CODE_CH0);
    assign we_code[1] = wr_commit & hit(paddr_i, `DACC_OFF_CODE_CH1);
    assign we_ctl = wr_commit & hit(paddr_i, `DACC_OFF_CONTROL);

    // Code writes also pulse load so an enabled channel restarts at once
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            code_q[0] <= `DACC_CODE_RST;
            code_q[1] <= `DACC_CODE_RST;
            {oe1_q, oe0_q, joint_q} <= `DACC_CTL_BITS_RST;
            load_q <= `DACC_LOAD_NONE;
        end else begin
            load_q <= `DACC_LOAD_NONE;
            if (we_code[0]) begin
                code_q[0] <= pwdata_i[7:0];
                load_q[0] <= 1'b1;
            end
            if (we_code[1]) begin
                code_q[1] <= pwdata_i[7:0];
                load_q[1] <= 1'b1;
            end
            if (we_ctl) begin
                oe1_q <= pwdata_i[`DACC_CTL_OE1];
                oe0_q <= pwdata_i[`DACC_CTL_OE0];
                joint_q <= pwdata_i[`DACC_CTL_JOINT];
                // Bits four to zero are constant and ignore writes
            end
        end
    end

    // A code written during standby lands at once, but the channel timer is
    // frozen; the restart is kept pending and issued when standby ends
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_q <= `DACC_LOAD_NONE;
        end else if (standby_s) begin
            pend_q <= pend_q | load_q;
        end else begin
            pend_q <= `DACC_LOAD_NONE;
        end
    end

    assign load = load_q | pend_q;
    assign oe = {oe1_q, oe0_q};

    // Module stop halts conversion; standby freezes each channel as it stands
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_chan
            // Joint bit converts a channel without driving its pin
            assign conv_en[g] = (oe[g] | joint_q) & ~stop_s;
            dacc_chan #(
                .CONV_CYCLES(CONV_CYCLES),
                .CNT_W(CNT_W)
            ) u_chan (
                .mclk_i(mclk_i),
                .nrst_i(nrst_i),
                .conv_en_i(conv_en[g]),
                .load_i(load[g]),
                .hold_i(standby_s),
                .code_i(code_q[g]),
                .result_o(result[g]),
                .valid_o(valid[g])
            );
        end
    endgenerate

    // Core scales code by Vref/256; code goes out unchanged for that reason.
    // Standby freezes the held value so the pin level is kept
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            analog_out_ch0_o <= `DACC_CODE_RST;
            analog_out_ch1_o <= `DACC_CODE_RST;
        end else if (!standby_s) begin
            analog_out_ch0_o <= result[0];
            analog_out_ch1_o <= result[1];
        end
    end

    // Drive ignores the joint bit stop removes drive and
    // valid on the same edge, so valid never stands on an undriven pin
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            drive_ch0_o <= 1'b0;
            drive_ch1_o <= 1'b0;
        end else if (!standby_s) begin
            drive_ch0_o <= oe0_q & ~stop_s;
            drive_ch1_o <= oe1_q & ~stop_s;
        end
    end

    // Valid needs the enable too: a joint-only channel converts unseen
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            valid_ch0_o <= 1'b0;
            valid_ch1_o <= 1'b0;
        end else if (!standby_s) begin
            valid_ch0_o <= valid[0] & oe0_q & ~stop_s;
            valid_ch1_o <= valid[1] & oe1_q & ~stop_s;
        end
    end
endmodule // dacc_top

// ===== verification/dacc_checker.sv
// Purpose: Port-level checks of the converter control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound into dacc_top at the foot of this file
`timescale 1ns/1ps
`include "dacc_defs.vh"
module dacc_checker (
    input logic mclk_i,
    input logic nrst_i,
    input logic psel_i,
    input logic penable_i,
    input logic pwrite_i,
    input logic [7:0] paddr_i,
    input logic [31:0] prdata_o,
    input logic pready_o,
    input logic pslverr_o,
    input logic module_stop_i,
    input logic standby_i,
    input logic [7:0] analog_out_ch0_o,
    input logic drive_ch0_o,
    input logic drive_ch1_o,
    input logic valid_ch0_o,
    input logic valid_ch1_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    property p_apb_wait;
        $rose(penable_i) && psel_i |=> !pready_o ##1 pready_o;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("answer off time");
    property p_rdy_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
    property p_rsvd_ones;
        pready_o && !pwrite_i && !pslverr_o && paddr_i == `DACC_OFF_CONTROL
            |-> prdata_o[4:0] == 5'h1f;
    endproperty
    a_rsvd_ones: assert property (p_rsvd_ones) else $error("low bits not ones");
    property p_upper_zero;
        pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
    property p_stop_err;
        module_stop_i [*6] ##0 pready_o |-> pslverr_o;
    endproperty
    a_stop_err: assert property (p_stop_err) else $error("access in stop");
    property p_stop_drv;
        module_stop_i [*5] |-> !drive_ch0_o && !drive_ch1_o;
    endproperty
    a_stop_drv: assert property (p_stop_drv) else $error("drive in stop");
    property p_hold;
        valid_ch0_o && $past(valid_ch0_o) |-> $stable(analog_out_ch0_o);
    endproperty
    a_hold: assert property (p_hold) else $error("held value moved");
    property p_vd0;
        valid_ch0_o |-> drive_ch0_o;
    endproperty
    a_vd0: assert property (p_vd0) else $error("valid0 undriven");
    property p_vd1;
        valid_ch1_o |-> drive_ch1_o;
    endproperty
    a_vd1: assert property (p_vd1) else $error("valid1 undriven");
    property p_stby;
        standby_i [*5] |-> $stable(analog_out_ch0_o) && $stable(valid_ch0_o);
    endproperty
    a_stby: assert property (p_stby) else $error("moved in standby");
    c_v0: cover property ($rose(valid_ch0_o));
    c_v1: cover property ($rose(valid_ch1_o));
    c_err: cover property (pready_o && pslverr_o);
endmodule // dacc_checker
bind dacc_top dacc_checker u_chk (.mclk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .prdata_o, .pready_o, .pslverr_o, .module_stop_i, .standby_i,
    .analog_out_ch0_o, .drive_ch0_o, .drive_ch1_o, .valid_ch0_o, .valid_ch1_o);

// ===== verification/dacc_top_bench.sv
// Purpose: Self-checking bench of the converter control block
// Assumes: Conversion shortened to 10 cycles
// Notes: Codes come from an LFSR seeded at 57
`timescale 1ns/1ps
`include "dacc_defs.vh"
module dacc_top_bench;
    localparam int CV = 10;
    localparam logic [7:0] A0 = `DACC_OFF_CODE_CH0;
    localparam logic [7:0] AC = `DACC_OFF_CONTROL;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic stop = 1'b1, stby = 1'b0, rdy, serr, err, d0, d1, v0, v1;
    logic [7:0] paddr = 8'h00, rs = 8'h39, c0, c1, old, o0, o1;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [2:0] m;
    int errors = 0, compares = 0, cyc = 0;
    dacc_top #(.CONV_TIME_NS(40)) DUT (.mclk_i(clk), .nrst_i(nrst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .pstrb_i(4'hf),
        .prdata_o(prd), .pready_o(rdy), .pslverr_o(serr), .module_stop_i(stop),
        .standby_i(stby), .analog_out_ch0_o(o0), .analog_out_ch1_o(o1), .drive_ch0_o(d0),
        .drive_ch1_o(d1), .valid_ch0_o(v0), .valid_ch1_o(v1));
    initial forever #2 clk = ~clk;
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Joint bit converts both channels whatever the enables say
    function automatic logic [1:0] conv(input logic [2:0] c);
        return {c[2] | c[0], c[1] | c[0]};
    endfunction
    task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        err = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, AC, 32'h0);
        chk("stop_err", err, 1);
        stop <= 1'b0;
        wt(3);
        apb(1'b1, AC, 32'h0);
        apb(1'b0, AC, 32'h0);
        chk("ctl", rd, 32'h1f);
        apb(1'b0, `DACC_OFF_CODE_CH1, 32'h0);
        chk("code_rst", rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", err, 1);
        for (int i = 0; i < 8; i++) begin
            m = i[2:0];
            rs = nx(rs);
            c0 = rs;
            rs = nx(rs);
            c1 = rs;
            apb(1'b1, A0, {24'h0, c0});
            apb(1'b1, `DACC_OFF_CODE_CH1, {24'h0, c1});
            apb(1'b1, AC, {24'h0, m, 5'h00});
            wt(CV + 4);
            chk("drive", {d1, d0}, {m[2], m[1]});
            chk("valid", {v1, v0}, {m[2], m[1]});
            if (m[1]) chk("out0", o0, c0);
            if (m[2]) chk("out1", o1, c1);
            apb(1'b0, `DACC_OFF_STATUS, 32'h0);
            chk("conv", rd[1:0], conv(m));
        end
        rs = nx(rs);
        c0 = rs;
        apb(1'b1, A0, {24'h0, c0});
        wt(3);
        chk("restart", {v1, v0}, 2'b10);
        wt(CV + 1);
        chk("out0_new", o0, c0);
        apb(1'b1, AC, 32'h40);
        wt(2);
        chk("oe1_off", {d1, v1, d0}, 3'b001);
        old = c0;
        rs = nx(rs);
        c0 = rs;
        stby <= 1'b1;
        wt(4);
        apb(1'b1, A0, {24'h0, c0});
        wt(CV + 4);
        chk("hold", {v0, o0}, {1'b1, old});
        apb(1'b0, A0, 32'h0);
        chk("code_rw", rd, {24'h0, c0});
        stby <= 1'b0;
        wt(CV + 6);
        chk("resume", o0, c0);
        stop <= 1'b1;
        wt(5);
        chk("stop_drv", d0, 0);
        apb(1'b1, AC, 32'he0);
        chk("stop_wr", err, 1);
        finish_test();
    end
endmodule // dacc_top_bench
